// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vbp_map.svh"

module testbench;
   import vbp_pkg::*;
   logic          clock, reset, warm_reset, compare_nonsecure, preempt;
   logic          awvalid, awready, wvalid, wready, bvalid, bready;
   logic          arvalid, arready, rvalid, rready, system_reset_request;
   logic [11:0]   awaddr, araddr;
   logic [2:0]    awprot, arprot;
   logic [31:0]   wdata, rdata, vector_table_base, d;
   logic [3:0]    wstrb;
   logic [1:0]    bresp, rresp, r;
   logic [7:0]    pending_priority, active_priority;
   logic          sr;
   logic          sr2, plain_reset_request;
   logic [31:0]   plain_rdata, d2;
   irc_state_type control_state;
   int            mismatches, checks_done, cycles;

   vector_base_and_priority_ctrl vector_base_and_priority_ctrl_i (
      .clock(clock), .reset(reset), .warm_reset(warm_reset),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .vector_table_base(vector_table_base),
      .control_state(control_state),
      .system_reset_request(system_reset_request),
      .pending_priority(pending_priority),
      .active_priority(active_priority),
      .compare_nonsecure(compare_nonsecure), .preempt(preempt));

   // same block without the security extension, on the same bus inputs
   if (1) begin : g_plain
      vector_base_and_priority_ctrl #(
         .SECURITY_EXT (1'b0)
      ) vector_base_and_priority_ctrl_i (
         .clock(clock), .reset(reset), .warm_reset(warm_reset),
         .awvalid(awvalid), .awready(), .awaddr(awaddr),
         .awprot(awprot), .wvalid(wvalid), .wready(),
         .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready),
         .bresp(), .arvalid(arvalid), .arready(),
         .araddr(araddr), .arprot(arprot), .rvalid(),
         .rready(rready), .rdata(plain_rdata), .rresp(),
         .vector_table_base(),
         .control_state(),
         .system_reset_request(plain_reset_request),
         .pending_priority(pending_priority),
         .active_priority(active_priority),
         .compare_nonsecure(compare_nonsecure), .preempt());
   end

   always #2.5 clock = ~clock;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test;
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   // handshakes sampled at the falling edge, where readies are settled
   // answer ready raised a cycle late so the slave must hold its answer
   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     input logic ns);
      logic ta, tw, tb, vb;
      @(posedge clock);
      awvalid <= 1'b1;
      awaddr  <= a;
      awprot  <= {1'b0, ns, 1'b0};
      wvalid  <= 1'b1;
      wdata   <= v;
      wstrb   <= 4'hf;
      sr = 1'b0;
      sr2 = 1'b0;
      do begin
         @(negedge clock);
         ta = awvalid && awready;
         tw = wvalid && wready;
         vb = bvalid;
         tb = bvalid && bready;
         r  = bresp;
         sr = sr | system_reset_request;
         sr2 = sr2 | plain_reset_request;
         @(posedge clock);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         else if (vb) bready <= 1'b1;
      end while (!tb);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic ns);
      logic ta, tr, vr;
      @(posedge clock);
      arvalid <= 1'b1;
      araddr  <= a;
      arprot  <= {1'b0, ns, 1'b0};
      do begin
         @(negedge clock);
         ta = arvalid && arready;
         vr = rvalid;
         tr = rvalid && rready;
         d  = rdata;
         d2 = plain_rdata;
         r  = rresp;
         @(posedge clock);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         else if (vr) rready <= 1'b1;
      end while (!tr);
   endtask : rd

   task automatic rdc(input logic [11:0] a, input logic ns,
                      input logic [31:0] exp);
      rd(a, ns);
      check(d, exp);
      check(32'(r), 32'h0);
   endtask : rdc

   task automatic pre(input logic [7:0] p, input logic ns, input logic exp);
      @(posedge clock);
      pending_priority  <= p;
      active_priority   <= 8'hff;
      compare_nonsecure <= ns;
      @(posedge clock);
      @(negedge clock);
      check(32'(preempt), 32'(exp));
   endtask : pre

   task automatic t_vector_base;
      rdc(`VTB_OFFSET, 1'b0, 32'h0);
      wr(`VTB_OFFSET, 32'hffffffff, 1'b0);
      check(32'(r), 32'h0);
      rdc(`VTB_OFFSET, 1'b0, 32'hffffff80);
      rdc(`VTB_OFFSET, 1'b1, 32'hffffff80);
      // 32-word aligned table written from the other state
      wr(`VTB_OFFSET, 32'h00001000, 1'b1);
      rdc(`VTB_OFFSET, 1'b0, 32'h00001000);
      check(vector_table_base, 32'h00001000);
   endtask : t_vector_base

   task automatic t_key_and_banks;
      rdc(`IRC_OFFSET, 1'b0, 32'hfa050000);
      wr(`IRC_OFFSET, 32'h12340700, 1'b0);
      rdc(`IRC_OFFSET, 1'b0, 32'hfa050000);
      wr(`IRC_OFFSET, 32'h05fa0300, 1'b0);
      rdc(`IRC_OFFSET, 1'b0, 32'hfa050300);
      wr(`IRC_OFFSET, 32'h05fa6508, 1'b1);
      rdc(`IRC_OFFSET, 1'b1, 32'hfa050500);
      rdc(`IRC_OFFSET, 1'b0, 32'hfa050300);
      wr(`IRC_OFFSET, 32'h05fa6708, 1'b0);
      rdc(`IRC_OFFSET, 1'b0, 32'hfa056708);
      check(d2, 32'hfa050700);
      rdc(`IRC_OFFSET, 1'b1, 32'hfa052500);
      check({23'h0, control_state}, 32'h000001fd);
   endtask : t_key_and_banks

   task automatic t_reset_request;
      wr(`IRC_OFFSET, 32'h05fa0504, 1'b1);
      check(32'(sr), 32'h0);
      wr(`IRC_OFFSET, 32'h05fa670c, 1'b0);
      check(32'(sr), 32'h1);
      check(32'(sr2), 32'h0);
      wr(`IRC_OFFSET, 32'h05fa6708, 1'b0);
      check(32'(sr), 32'h0);
      wr(`IRC_OFFSET, 32'h1234670c, 1'b0);
      check(32'(sr), 32'h0);
      wr(`IRC_OFFSET, 32'h05fa6704, 1'b0);
      check(32'(sr), 32'h1);
      wr(`IRC_OFFSET, 32'h05fa0504, 1'b1);
      check(32'(sr), 32'h1);
      rdc(`IRC_OFFSET, 1'b0, 32'hfa056700);
   endtask : t_reset_request

   task automatic t_warm_and_unmapped;
      wr(`IRC_OFFSET, 32'h05fa6708, 1'b0);
      @(posedge clock);
      warm_reset <= 1'b1;
      @(posedge clock);
      warm_reset <= 1'b0;
      rdc(`VTB_OFFSET, 1'b0, 32'h0);
      rdc(`IRC_OFFSET, 1'b0, 32'hfa050000);
      rd(12'h008, 1'b0);
      check(32'(r), 32'h2);
      check(d, 32'h0);
      wr(12'h008, 32'hffffffff, 1'b0);
      check(32'(r), 32'h2);
      rdc(`VTB_OFFSET, 1'b0, 32'h0);
   endtask : t_warm_and_unmapped

   task automatic t_preempt;
      for (int n = 0; n < 8; n++) begin
         wr(`IRC_OFFSET, 32'h05fa0000 | (32'(n) << 8), 1'b0);
         // lower only in the top subpriority bit, then in the group lsb
         pre(8'hff ^ (8'h01 << n), 1'b0, 1'b0);
         pre(8'hff ^ (8'h02 << n), 1'b0, n < 7);
      end
      wr(`IRC_OFFSET, 32'h05fa0500, 1'b1);
      pre(8'hdf, 1'b1, 1'b0);
      pre(8'hbf, 1'b1, 1'b1);
   endtask : t_preempt

   initial begin
      clock = 1'b0;
      reset = 1'b1;
      warm_reset = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, awprot, arprot} = 30'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      {pending_priority, active_priority, compare_nonsecure} = 17'h0;
      mismatches = 0;
      checks_done = 0;
      cycles = 0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      t_vector_base();
      t_key_and_banks();
      t_reset_request();
      t_warm_and_unmapped();
      t_preempt();
      stop_test();
   end
endmodule : testbench

`default_nettype wire

// ### dv/vbp_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "vbp_map.svh"

module vbp_chk (
   // clock and resets
   input wire logic                   clock,
   input wire logic                   reset,
   input wire logic                   warm_reset,
   // bus handshakes
   input wire logic                   arvalid,
   input wire logic                   arready,
   input wire logic [11:0]            araddr,
   input wire logic                   rvalid,
   input wire logic                   rready,
   input wire logic [31:0]            rdata,
   input wire logic [1:0]             rresp,
   input wire logic                   bvalid,
   input wire logic                   bready,
   input wire logic [1:0]             bresp,
   // core side
   input wire logic [31:0]            vector_table_base,
   input wire vbp_pkg::irc_state_type control_state,
   input wire logic                   system_reset_request,
   input wire logic [7:0]             pending_priority,
   input wire logic [7:0]             active_priority,
   input wire logic                   compare_nonsecure,
   input wire logic                   preempt
);
   import vbp_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic       rd_irc;
   logic [2:0] split;
   logic [7:0] mask;
   logic       want;
   always_ff @(posedge clock) begin
      if (arvalid && arready) rd_irc <= (araddr == `IRC_OFFSET);
   end
   // group bits of the bank selected for the compare
   always_comb begin
      split = compare_nonsecure ?
              control_state.priority_split_point_nonsecure :
              control_state.priority_split_point_secure;
      mask = 8'hff << ({1'b0, split} + 4'h1);
      want = (pending_priority & mask) < (active_priority & mask);
   end
   sequence s_ar_taken;
      arvalid && arready;
   endsequence
   sequence s_irc_data;
      rvalid && rd_irc && rresp == `AXI_RESP_OKAY;
   endsequence
   a_vtb_low_zero:
      assert property (vector_table_base[6:0] == 7'h0)
      else $error("vector base low bits set");
   a_key_readback:
      assert property (s_irc_data |-> rdata[31:16] == `IRC_KEY_READ)
      else $error("key readback wrong");
   a_fixed_zero_bits:
      assert property (s_irc_data |-> rdata[15] == 1'b0 && rdata[2:1] == 2'h0)
      else $error("fixed control bits not zero");
   a_read_latency:
      assert property (s_ar_taken |=> rvalid)
      else $error("read answer late");
   a_read_hold:
      assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_write_hold:
      assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_fault_warm_clear:
      assert property (warm_reset |=>
                       !control_state.fault_nmi_nonsecure_enable)
      else $error("fault enable kept over warm reset");
   a_secure_warm_clear:
      assert property (warm_reset |=> !control_state.reset_request_secure_only
                       && vector_table_base == 32'h0)
      else $error("state kept over warm reset");
   a_reset_pulse:
      assert property (system_reset_request |->
                       $rose(bvalid) ##1 !system_reset_request)
      else $error("reset request not a write pulse");
   a_group_only:
      assert property (1'b1 |=> preempt == $past(want))
      else $error("preempt not from group bits");
endmodule : vbp_chk

bind vector_base_and_priority_ctrl vbp_chk vbp_chk_i (
   .clock(clock), .reset(reset), .warm_reset(warm_reset),
   .arvalid(arvalid), .arready(arready), .araddr(araddr),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
   .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .vector_table_base(vector_table_base),
   .control_state(control_state),
   .system_reset_request(system_reset_request),
   .pending_priority(pending_priority),
   .active_priority(active_priority),
   .compare_nonsecure(compare_nonsecure), .preempt(preempt));

`default_nettype wire

// ### rtl/group_priority_compare.sv
`timescale 1ns/1ps
`default_nettype none

module group_priority_compare (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // priorities to compare and the group mask in force
   input  wire logic [7:0] pending_priority,
   input  wire logic [7:0] active_priority,
   input  wire logic [7:0] group_mask,
   // pending one pre-empts the active one
   output logic            preempt
);
   import vbp_pkg::*;

   logic next_preempt;

   always_comb begin
      // lower group value wins; subpriority is masked out
      next_preempt = (pending_priority & group_mask) <
                     (active_priority & group_mask);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         preempt <= 1'b0;
      end else begin
         preempt <= next_preempt;
      end
   end

endmodule : group_priority_compare

`default_nettype wire

// ### rtl/split_mask.sv
`timescale 1ns/1ps
`default_nettype none

// group bit mask for a priority split point, unimplemented bits cleared
module split_mask #(
   parameter int PRIO_BITS = 8
) (
   // split point
   input  wire logic [2:0] split,
   // group priority bits of an 8-bit priority
   output logic [7:0]      group_mask
);
   import vbp_pkg::*;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         // low bits absent from the implementation never count
         assign group_mask[i] = (4'(i) > {1'b0, split}) &&
                                (i >= 8 - PRIO_BITS);
      end
   endgenerate

endmodule : split_mask

`default_nettype wire

// ### rtl/vbp_map.svh
`ifndef VBP_MAP_SVH
`define VBP_MAP_SVH

// register word offsets (byte addresses)
`define VTB_OFFSET          12'h000
`define IRC_OFFSET          12'h004

// vector_table_base layout
`define VTB_BASE_LSB        7
`define VTB_BASE_RESET      25'h0000000

// interrupt_reset_control layout
`define IRC_KEY_LSB         16
`define IRC_KEY_WRITE       16'h05fa
`define IRC_KEY_READ        16'hfa05
`define IRC_ENDIAN_BIT      15
`define IRC_BOOST_BIT       14
`define IRC_FAULT_NS_BIT    13
`define IRC_SPLIT_LSB       8
`define IRC_SEC_ONLY_BIT    3
`define IRC_RESET_REQ_BIT   2
`define IRC_CLR_ACTIVE_BIT  1
`define IRC_ENDIAN_VALUE    1'h0
`define IRC_BOOST_RESET     1'h0
`define IRC_FAULT_NS_RESET  1'h0
`define IRC_SEC_ONLY_RESET  1'h0
`define IRC_SPLIT_RESET     3'h0

// bus answers
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ### rtl/vbp_pkg.sv
package vbp_pkg;

   typedef struct packed {
      logic       secure_priority_boost;
      logic       fault_nmi_nonsecure_enable;
      logic       reset_request_secure_only;
      logic [2:0] priority_split_point_secure;
      logic [2:0] priority_split_point_nonsecure;
   } irc_state_type;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  strb;
   } wdata_type;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } write_state_type;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } read_state_type;

endpackage : vbp_pkg

// ### rtl/vector_base_and_priority_ctrl.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "vbp_map.svh"

module vector_base_and_priority_ctrl #(
   parameter int ADDR_WIDTH    = 12,
   parameter bit SECURITY_EXT  = 1'b1,
   parameter int PRIO_BITS     = 8
) (
   // clock and resets
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  warm_reset,
   // axi4-lite write address
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [ADDR_WIDTH-1:0] awaddr,
   input  wire logic [2:0]            awprot,
   // axi4-lite write data
   input  wire logic                  wvalid,
   output logic                       wready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   // axi4-lite write response
   output logic                       bvalid,
   input  wire logic                  bready,
   output logic [1:0]                 bresp,
   // axi4-lite read address
   input  wire logic                  arvalid,
   output logic                       arready,
   input  wire logic [ADDR_WIDTH-1:0] araddr,
   input  wire logic [2:0]            arprot,
   // axi4-lite read data
   output logic                       rvalid,
   input  wire logic                  rready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   // configuration toward the core
   output logic [31:0]                vector_table_base,
   output vbp_pkg::irc_state_type     control_state,
   output logic                       system_reset_request,
   // pre-emption check
   input  wire logic [7:0]            pending_priority,
   input  wire logic [7:0]            active_priority,
   input  wire logic                  compare_nonsecure,
   output logic                       preempt
);
   import vbp_pkg::*;

   // write channel state
   write_state_type         write_state;
   write_state_type         next_write_state;
   logic                    aw_held;
   logic                    next_aw_held;
   logic [ADDR_WIDTH-1:0]   aw_addr;
   logic [ADDR_WIDTH-1:0]   next_aw_addr;
   logic                    aw_nonsecure;
   logic                    next_aw_nonsecure;
   logic                    w_held;
   logic                    next_w_held;
   wdata_type               w_word;
   wdata_type               next_w_word;
   logic [1:0]              next_bresp;
   logic                    write_fire;

   // read channel state
   read_state_type          read_state;
   read_state_type          next_read_state;
   logic [31:0]             next_rdata;
   logic [1:0]              next_rresp;

   // register state
   logic [24:0]             table_base_offset;
   logic [24:0]             next_table_base_offset;
   irc_state_type           irc;
   irc_state_type           next_irc;
   logic                    next_reset_request;

   // write decode and pre-emption group masks
   logic                    hit_vtb;
   logic                    hit_irc;
   logic                    key_ok;
   logic                    secure_write;
   logic [7:0]              mask_secure;
   logic [7:0]              mask_nonsecure;

   // ---------------- write channel ----------------
   assign awready    = (write_state == WR_IDLE) && !aw_held;
   assign wready     = (write_state == WR_IDLE) && !w_held;
   assign bvalid     = (write_state == WR_RESP);
   assign write_fire = (write_state == WR_IDLE) && aw_held && w_held;

   always_comb begin
      next_write_state  = write_state;
      next_aw_held      = aw_held;
      next_aw_addr      = aw_addr;
      next_aw_nonsecure = aw_nonsecure;
      next_w_held       = w_held;
      next_w_word       = w_word;
      next_bresp        = bresp;
      case (write_state)
         WR_IDLE: begin
            // address and data may arrive in either order
            if (awvalid && awready) begin
               next_aw_held      = 1'b1;
               next_aw_addr      = awaddr;
               next_aw_nonsecure = awprot[1];
            end
            if (wvalid && wready) begin
               next_w_held = 1'b1;
               next_w_word = '{data: wdata, strb: wstrb};
            end
            if (write_fire) begin
               next_aw_held     = 1'b0;
               next_w_held      = 1'b0;
               next_bresp       = (hit_vtb || hit_irc) ?
                                  `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
               next_write_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (bready) begin
               next_write_state = WR_IDLE;
            end
         end
         default: begin
            next_write_state = WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         write_state  <= WR_IDLE;
         aw_held      <= 1'b0;
         aw_addr      <= '0;
         aw_nonsecure <= 1'b0;
         w_held       <= 1'b0;
         w_word       <= '0;
         bresp        <= `AXI_RESP_OKAY;
      end else begin
         write_state  <= next_write_state;
         aw_held      <= next_aw_held;
         aw_addr      <= next_aw_addr;
         aw_nonsecure <= next_aw_nonsecure;
         w_held       <= next_w_held;
         w_word       <= next_w_word;
         bresp        <= next_bresp;
      end
   end

   // ---------------- register writes ----------------
   always_comb begin
      hit_vtb = 1'b0;
      hit_irc = 1'b0;
      if (aw_addr == ADDR_WIDTH'(`VTB_OFFSET)) begin
         hit_vtb = 1'b1;
      end else if (aw_addr == ADDR_WIDTH'(`IRC_OFFSET)) begin
         hit_irc = 1'b1;
      end
   end

   // key must arrive whole in the upper halfword
   assign key_ok = (w_word.strb[3:2] == 2'b11) &&
                   (w_word.data[31:`IRC_KEY_LSB] == `IRC_KEY_WRITE);
   assign secure_write = SECURITY_EXT && !aw_nonsecure;

   always_comb begin
      next_table_base_offset = table_base_offset;
      next_irc               = irc;
      next_reset_request     = 1'b0;
      if (write_fire && hit_vtb) begin
         // one copy, whatever the security of the access
         for (int b = 0; b < 4; b++) begin
            if (w_word.strb[b]) begin
               for (int i = 0; i < 8; i++) begin
                  if (b * 8 + i >= `VTB_BASE_LSB) begin
                     next_table_base_offset[b * 8 + i - `VTB_BASE_LSB] =
                        w_word.data[b * 8 + i];
                  end
               end
            end
         end
      end
      if (write_fire && hit_irc && key_ok) begin
         if (w_word.strb[1]) begin
            if (secure_write) begin
               next_irc.secure_priority_boost =
                  w_word.data[`IRC_BOOST_BIT];
               next_irc.fault_nmi_nonsecure_enable =
                  w_word.data[`IRC_FAULT_NS_BIT];
            end
            // split point is banked per security state
            if (aw_nonsecure) begin
               next_irc.priority_split_point_nonsecure =
                  w_word.data[`IRC_SPLIT_LSB +: 3];
            end else begin
               next_irc.priority_split_point_secure =
                  w_word.data[`IRC_SPLIT_LSB +: 3];
            end
         end
         if (w_word.strb[0]) begin
            if (secure_write) begin
               next_irc.reset_request_secure_only =
                  w_word.data[`IRC_SEC_ONLY_BIT];
            end
            // request only with the security extension, when the reset bit is open to this state
            next_reset_request = SECURITY_EXT &&
               w_word.data[`IRC_RESET_REQ_BIT] &&
               (!aw_nonsecure || !irc.reset_request_secure_only);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset || warm_reset) begin
         table_base_offset    <= `VTB_BASE_RESET;
         irc.secure_priority_boost          <= `IRC_BOOST_RESET;
         irc.fault_nmi_nonsecure_enable     <= `IRC_FAULT_NS_RESET;
         irc.reset_request_secure_only      <= `IRC_SEC_ONLY_RESET;
         irc.priority_split_point_secure    <= `IRC_SPLIT_RESET;
         irc.priority_split_point_nonsecure <= `IRC_SPLIT_RESET;
         system_reset_request <= 1'b0;
      end else begin
         table_base_offset    <= next_table_base_offset;
         irc                  <= next_irc;
         system_reset_request <= next_reset_request;
      end
   end

   assign vector_table_base = {table_base_offset, 7'h00};
   assign control_state     = irc;

   // ---------------- read channel ----------------
   assign arready = (read_state == RD_IDLE);
   assign rvalid  = (read_state == RD_DATA);

   always_comb begin
      next_read_state = read_state;
      next_rdata      = rdata;
      next_rresp      = rresp;
      case (read_state)
         RD_IDLE: begin
            if (arvalid) begin
               next_read_state = RD_DATA;
               next_rdata      = 32'h00000000;
               next_rresp      = `AXI_RESP_OKAY;
               if (araddr == ADDR_WIDTH'(`VTB_OFFSET)) begin
                  next_rdata = {table_base_offset, 7'h00};
               end else if (araddr == ADDR_WIDTH'(`IRC_OFFSET)) begin
                  next_rdata[31:`IRC_KEY_LSB] = `IRC_KEY_READ;
                  next_rdata[`IRC_ENDIAN_BIT] = `IRC_ENDIAN_VALUE;
                  if (SECURITY_EXT && !arprot[1]) begin
                     next_rdata[`IRC_BOOST_BIT] =
                        irc.secure_priority_boost;
                     next_rdata[`IRC_SEC_ONLY_BIT] =
                        irc.reset_request_secure_only;
                  end
                  if (SECURITY_EXT) begin
                     next_rdata[`IRC_FAULT_NS_BIT] =
                        irc.fault_nmi_nonsecure_enable;
                  end
                  next_rdata[`IRC_SPLIT_LSB +: 3] = arprot[1] ?
                     irc.priority_split_point_nonsecure :
                     irc.priority_split_point_secure;
                  // reset request and clear-active always read zero
                  next_rdata[`IRC_RESET_REQ_BIT]  = 1'b0;
                  next_rdata[`IRC_CLR_ACTIVE_BIT] = 1'b0;
               end else begin
                  next_rresp = `AXI_RESP_SLVERR;
               end
            end
         end
         RD_DATA: begin
            if (rready) begin
               next_read_state = RD_IDLE;
            end
         end
         default: begin
            next_read_state = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         read_state <= RD_IDLE;
         rdata      <= 32'h00000000;
         rresp      <= `AXI_RESP_OKAY;
      end else begin
         read_state <= next_read_state;
         rdata      <= next_rdata;
         rresp      <= next_rresp;
      end
   end

   // ---------------- pre-emption ----------------
   split_mask #(
      .PRIO_BITS (PRIO_BITS)
   ) u_mask_secure (
      .split      (irc.priority_split_point_secure),
      .group_mask (mask_secure)
   );

   split_mask #(
      .PRIO_BITS (PRIO_BITS)
   ) u_mask_nonsecure (
      .split      (irc.priority_split_point_nonsecure),
      .group_mask (mask_nonsecure)
   );

   group_priority_compare u_compare (
      .clock            (clock),
      .reset            (reset),
      .pending_priority (pending_priority),
      .active_priority  (active_priority),
      .group_mask       (compare_nonsecure ? mask_nonsecure
                                           : mask_secure),
      .preempt          (preempt)
   );

endmodule : vector_base_and_priority_ctrl

`default_nettype wire
